// file: hw/fbc_consts.svh
// Timing constants for the flash bus host controller.
// Assumes a 25 MHz sys_clk; every count is derived from a time in ns.
`ifndef FBC_CONSTS_SVH
`define FBC_CONSTS_SVH

`define FBC_CLK_NS 40
// Write cycle time, slowest speed grade
`define FBC_T_WC_NS 150
// Write pulse low and write pulse high times, slowest grade
`define FBC_T_WP_NS 70
`define FBC_T_WPH_NS 30
// Restart pulse width and restart high time before a read
`define FBC_T_RP_NS 500
`define FBC_T_RH_NS 200
// Restart-low to ready, with and without an embedded algorithm running
`define FBC_T_READY_BUSY_NS 20000
`define FBC_T_READY_IDLE_NS 500
// Device raises busy within this time after the final command write
`define FBC_T_BUSY_NS 200
// Elevated restart level setup before unprotected writes
`define FBC_T_RSP_NS 4000
// Read access time, slowest grade
`define FBC_T_ACC_NS 150
// Least times round up, one cycle at the least
`define FBC_CYC_UP(t) (((t) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_WP_CYC `FBC_CYC_UP(`FBC_T_WP_NS)
`define FBC_WPH_CYC `FBC_CYC_UP(`FBC_T_WPH_NS)
`define FBC_WC_CYC `FBC_CYC_UP(`FBC_T_WC_NS)
`define FBC_RP_CYC `FBC_CYC_UP(`FBC_T_RP_NS)
`define FBC_RH_CYC `FBC_CYC_UP(`FBC_T_RH_NS)
`define FBC_RDY_BUSY_CYC `FBC_CYC_UP(`FBC_T_READY_BUSY_NS)
`define FBC_RDY_IDLE_CYC `FBC_CYC_UP(`FBC_T_READY_IDLE_NS)
`define FBC_BUSY_CYC `FBC_CYC_UP(`FBC_T_BUSY_NS)
`define FBC_RSP_CYC `FBC_CYC_UP(`FBC_T_RSP_NS)
`define FBC_ACC_CYC `FBC_CYC_UP(`FBC_T_ACC_NS)
`define FBC_CNT_W 10
// Address bits 6,1,0 for protect and unprotect pulses
`define FBC_PROT_A6 1'h0
`define FBC_UNPROT_A6 1'h1
`define FBC_PROT_A1 1'h1
`define FBC_PROT_A0 1'h0
`define FBC_ADDR_W 20
`define FBC_DATA_W 16

`endif

// file: hw/fbc_pkg.sv
// Types for the flash bus host controller.
// Assumes fbc_consts.svh is compiled alongside.
package fbc_pkg;
  typedef enum logic [2:0] {
    FBC_OP_READ = 3'h0,
    FBC_OP_WRITE = 3'h1,
    FBC_OP_RESTART = 3'h2,
    FBC_OP_PROTECT = 3'h3,
    FBC_OP_UNPROTECT = 3'h4
  } fbc_op_type;

  typedef enum logic [7:0] {
    FBC_ST_IDLE = 8'h01,
    FBC_ST_WR_LOW = 8'h02,
    FBC_ST_WR_HIGH = 8'h04,
    FBC_ST_RD = 8'h08,
    FBC_ST_RST_LOW = 8'h10,
    FBC_ST_RST_HIGH = 8'h20,
    FBC_ST_BUSY_WAIT = 8'h40,
    FBC_ST_UNPROT_SETUP = 8'h80
  } fbc_state_type;
endpackage

// file: hw/fbc_sync.sv
// Two-flip-flop synchroniser for a pin that arrives from the flash.
// Assumes the pin is asynchronous to sys_clk.
module fbc_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pin and synchronised level
  input wire logic pin_in,
  output logic level_out
);
  logic meta_r;
  logic level_r;

  // Only level_r reads meta_r
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= 1'h1;
      level_r <= 1'h1;
    end else if (clk_en) begin
      meta_r <= pin_in;
      level_r <= meta_r;
    end
  end

  assign level_out = level_r;
endmodule

// file: hw/fbc_host.sv
// Host controller driving an asynchronous parallel flash through its pins.
// Assumes a 25 MHz sys_clk; the flash pins are sampled through two flops.
`include "fbc_consts.svh"

module fbc_host (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Request port
  input wire logic req_valid,
  output logic req_ready,
  input wire fbc_pkg::fbc_op_type req_op,
  input wire logic [`FBC_ADDR_W-1:0] req_addr,
  input wire logic [`FBC_DATA_W-1:0] req_wdata,
  input wire logic req_last,
  input wire logic req_fast_status,
  // Answer port
  output logic rsp_valid,
  output logic [`FBC_DATA_W-1:0] rsp_rdata,
  output logic dev_busy,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_restart_n,
  output logic flash_restart_hv,
  output logic [`FBC_ADDR_W-1:0] flash_addr,
  output logic [`FBC_DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [`FBC_DATA_W-1:0] flash_dq_in,
  input wire logic done_flag_in
);
  ////////////////////////////////////////////////////////////////////////////
  fbc_pkg::fbc_state_type state_r;
  logic [`FBC_CNT_W-1:0] cnt_r;
  logic [`FBC_CNT_W-1:0] rd_guard_r;
  logic [`FBC_DATA_W-1:0] dq_s1_r;
  logic [`FBC_DATA_W-1:0] dq_s2_r;
  logic done_sync;
  logic wait_busy_r;
  logic unprot_r;
  logic fast_status_r;

  fbc_sync u_done_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(done_flag_in),
    .level_out(done_sync)
  );

  // Data bus sampled through two flops before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else if (clk_en) begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // A restart is also taken during an embedded run, so that it can abort it
  assign req_ready = (state_r == fbc_pkg::FBC_ST_IDLE) && done_sync
    || (state_r == fbc_pkg::FBC_ST_IDLE || state_r == fbc_pkg::FBC_ST_BUSY_WAIT)
    && req_op == fbc_pkg::FBC_OP_RESTART;
  assign dev_busy = !done_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= fbc_pkg::FBC_ST_IDLE;
      cnt_r <= 10'h000;
      wait_busy_r <= 1'h0;
      fast_status_r <= 1'h0;
    end else if (clk_en) begin
      case (state_r)
        fbc_pkg::FBC_ST_IDLE: begin
          if (req_valid && req_ready) begin
            fast_status_r <= req_fast_status;
            case (req_op)
              fbc_pkg::FBC_OP_WRITE, fbc_pkg::FBC_OP_PROTECT,
              fbc_pkg::FBC_OP_UNPROTECT: begin
                wait_busy_r <= req_last;
                cnt_r <= 10'(`FBC_WP_CYC);
                state_r <= fbc_pkg::FBC_ST_WR_LOW;
                if (req_op != fbc_pkg::FBC_OP_WRITE) begin
                  // One cycle more, as the elevated level rises an edge after the take
                  cnt_r <= 10'(`FBC_RSP_CYC + 1);
                  state_r <= fbc_pkg::FBC_ST_UNPROT_SETUP;
                end
              end
              fbc_pkg::FBC_OP_RESTART: begin
                cnt_r <= 10'(`FBC_RP_CYC);
                state_r <= fbc_pkg::FBC_ST_RST_LOW;
              end
              default: begin
                // Reads wait for the post-restart guard
                cnt_r <= 10'(`FBC_ACC_CYC) + rd_guard_r;
                state_r <= fbc_pkg::FBC_ST_RD;
              end
            endcase
          end
        end
        fbc_pkg::FBC_ST_WR_LOW: begin
          if (cnt_r <= 10'h001) begin
            // High time covers both strobe-high and cycle spacing
            cnt_r <= 10'(`FBC_WC_CYC - `FBC_WP_CYC);
            state_r <= fbc_pkg::FBC_ST_WR_HIGH;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        fbc_pkg::FBC_ST_WR_HIGH: begin
          if (cnt_r <= 10'h001) begin
            if (wait_busy_r) begin
              wait_busy_r <= 1'h0;
              // Give the device time to drop the done flag
              cnt_r <= 10'(`FBC_BUSY_CYC + 2);
              state_r <= fbc_pkg::FBC_ST_BUSY_WAIT;
            end else begin
              state_r <= fbc_pkg::FBC_ST_IDLE;
            end
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        fbc_pkg::FBC_ST_BUSY_WAIT: begin
          // Program or erase runs until the flag returns; no timeout since
          // erase may last seconds
          if (req_valid && req_ready) begin
            cnt_r <= 10'(`FBC_RP_CYC);
            state_r <= fbc_pkg::FBC_ST_RST_LOW;
          end else if (cnt_r != 10'h000) begin
            cnt_r <= cnt_r - 10'h001;
          end else if (done_sync) begin
            state_r <= fbc_pkg::FBC_ST_IDLE;
          end
        end
        fbc_pkg::FBC_ST_UNPROT_SETUP: begin
          if (cnt_r <= 10'h001) begin
            cnt_r <= 10'(`FBC_WP_CYC);
            state_r <= fbc_pkg::FBC_ST_WR_LOW;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        fbc_pkg::FBC_ST_RD: begin
          if (cnt_r <= 10'h001) begin
            state_r <= fbc_pkg::FBC_ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        fbc_pkg::FBC_ST_RST_LOW: begin
          if (cnt_r <= 10'h001) begin
            state_r <= fbc_pkg::FBC_ST_RST_HIGH;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        fbc_pkg::FBC_ST_RST_HIGH: begin
          state_r <= fbc_pkg::FBC_ST_IDLE;
        end
        default: begin
          state_r <= fbc_pkg::FBC_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready-after-restart guard: reads held off until the device recovers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_guard_r <= 10'h000;
    end else if (clk_en) begin
      if (state_r == fbc_pkg::FBC_ST_RST_HIGH) begin
        // Idle restart: ready within 500 ns, plus restart high time
        rd_guard_r <= 10'(`FBC_RH_CYC + `FBC_RDY_IDLE_CYC);
      end else if (state_r == fbc_pkg::FBC_ST_RD && rd_guard_r != 10'h000) begin
        rd_guard_r <= 10'h000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unprotect mode: elevated restart held 4 us before writes start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unprot_r <= 1'h0;
    end else if (clk_en) begin
      if (state_r == fbc_pkg::FBC_ST_IDLE && req_valid && req_ready) begin
        unprot_r <= req_op == fbc_pkg::FBC_OP_PROTECT
          || req_op == fbc_pkg::FBC_OP_UNPROTECT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all from flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_ce_n <= 1'h1;
      flash_oe_n <= 1'h1;
      flash_we_n <= 1'h1;
      flash_restart_n <= 1'h1;
      flash_restart_hv <= 1'h0;
      flash_addr <= 20'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'h0;
    end else if (clk_en) begin
      flash_we_n <= 1'h1;
      flash_oe_n <= 1'h1;
      flash_ce_n <= 1'h1;
      flash_restart_n <= !(req_valid && req_ready && req_op == fbc_pkg::FBC_OP_RESTART) &&
        !(state_r == fbc_pkg::FBC_ST_RST_LOW && cnt_r > 10'h001);
      flash_restart_hv <= unprot_r && (state_r == fbc_pkg::FBC_ST_UNPROT_SETUP
        || state_r == fbc_pkg::FBC_ST_WR_LOW || state_r == fbc_pkg::FBC_ST_WR_HIGH);
      if (state_r == fbc_pkg::FBC_ST_IDLE && req_valid && req_ready) begin
        flash_addr <= req_addr;
        flash_dq_out <= req_wdata;
        if (req_op == fbc_pkg::FBC_OP_PROTECT) begin
          flash_addr[6] <= `FBC_PROT_A6;
          flash_addr[1] <= `FBC_PROT_A1;
          flash_addr[0] <= `FBC_PROT_A0;
        end else if (req_op == fbc_pkg::FBC_OP_UNPROTECT) begin
          flash_addr[6] <= `FBC_UNPROT_A6;
          flash_addr[1] <= `FBC_PROT_A1;
          flash_addr[0] <= `FBC_PROT_A0;
        end
        if (req_op == fbc_pkg::FBC_OP_READ) begin
          flash_ce_n <= 1'h0;
          // Fast status holds chip enable low between reads, except in the last read cycle; the guard delays output enable after restart
          flash_oe_n <= rd_guard_r != 10'h000;
        end else if (req_op == fbc_pkg::FBC_OP_WRITE) begin
          flash_ce_n <= 1'h0;
          flash_we_n <= 1'h0;
          flash_dq_oe <= 1'h1;
        end
      end else if (state_r == fbc_pkg::FBC_ST_UNPROT_SETUP) begin
        // Strobe falls only once the elevated level has settled
        flash_ce_n <= cnt_r > 10'h001;
        flash_we_n <= cnt_r > 10'h001;
        flash_dq_oe <= cnt_r <= 10'h001;
      end else if (state_r == fbc_pkg::FBC_ST_WR_LOW) begin
        flash_ce_n <= 1'h0;
        flash_we_n <= cnt_r <= 10'h001;
      end else if (state_r == fbc_pkg::FBC_ST_WR_HIGH) begin
        flash_ce_n <= !(cnt_r > 10'h001);
        flash_dq_oe <= cnt_r > 10'h001;
      end else if (state_r == fbc_pkg::FBC_ST_RD && cnt_r > 10'h001) begin
        flash_ce_n <= 1'h0;
        flash_oe_n <= cnt_r > 10'(`FBC_ACC_CYC);
      end else if (fast_status_r && state_r == fbc_pkg::FBC_ST_IDLE) begin
        flash_ce_n <= 1'h0;
      end
      if (state_r != fbc_pkg::FBC_ST_WR_HIGH && state_r != fbc_pkg::FBC_ST_WR_LOW
          && state_r != fbc_pkg::FBC_ST_UNPROT_SETUP
          && !(state_r == fbc_pkg::FBC_ST_IDLE && req_valid && req_ready)) begin
        flash_dq_oe <= 1'h0;
      end
    end
  end

  // Read answer: sampled data at end of access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid <= 1'h0;
      rsp_rdata <= 16'h0000;
    end else if (clk_en) begin
      rsp_valid <= state_r == fbc_pkg::FBC_ST_RD && cnt_r <= 10'h001;
      if (state_r == fbc_pkg::FBC_ST_RD && cnt_r <= 10'h001) begin
        rsp_rdata <= dq_s2_r;
      end
    end
  end
endmodule

// file: tb/fbc_host_chk.sv
// Checker of the flash host's pin timing, watching its ports only.
// Assumes clk_en stays high; bound into every fbc_host.
module fbc_host_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic rsp_valid,
  input wire logic dev_busy,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_restart_n,
  input wire logic flash_restart_hv,
  input wire logic flash_dq_oe,
  input wire logic done_flag_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] low_r;
  logic [7:0] hv_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Saturating counts, so a long hold never wraps back under the limit
  always_ff @(posedge sys_clk) begin
    if (rst || flash_restart_n) begin
      low_r <= 8'h0;
    end else if (low_r != 8'hff) begin
      low_r <= low_r + 8'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !flash_restart_hv) begin
      hv_r <= 8'h0;
    end else if (hv_r != 8'hff) begin
      hv_r <= hv_r + 8'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_pulse_low: assert property ($fell(flash_we_n) |-> !flash_we_n [*2])
    else $error("write strobe low too short");
  a_pulse_high: assert property ($rose(flash_we_n) |-> flash_we_n [*2])
    else $error("write strobe high too short");
  a_cycle_space: assert property ($fell(flash_we_n) |=> !$fell(flash_we_n) [*3])
    else $error("write cycles too close");
  a_restart_width: assert property ($rose(flash_restart_n) |-> low_r >= 8'hd)
    else $error("restart pulse too short");
  a_read_guard: assert property ($rose(flash_restart_n) |-> flash_oe_n [*5])
    else $error("read too soon after restart");
  a_busy_blocks: assert property (dev_busy && req_op != fbc_pkg::FBC_OP_RESTART |-> !req_ready)
    else $error("request offered while busy");
  a_ready_seen: assert property (done_flag_in [*3] |-> !dev_busy)
    else $error("ready flag not followed");
  a_busy_seen: assert property (!done_flag_in [*3] |-> dev_busy)
    else $error("busy flag not followed");
  a_write_drive: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
    else $error("write without data or select");
  a_no_clash: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("read while driving data");
  a_unprot_setup: assert property ($fell(flash_we_n) && flash_restart_hv |-> hv_r >= 8'h64)
    else $error("elevated level setup too short");
  c_write: cover property ($fell(flash_we_n));
  c_read: cover property (rsp_valid);
  c_restart: cover property ($rose(flash_restart_n));
  c_done: cover property ($fell(dev_busy));
  c_elevated: cover property ($fell(flash_we_n) && flash_restart_hv);
endmodule
bind fbc_host fbc_host_chk chk (.sys_clk(sys_clk), .rst(rst), .req_ready(req_ready),
  .req_op(req_op), .rsp_valid(rsp_valid), .dev_busy(dev_busy), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_restart_n(flash_restart_n),
  .flash_restart_hv(flash_restart_hv), .flash_dq_oe(flash_dq_oe),
  .done_flag_in(done_flag_in));

// file: tb/fbc_flash_model.sv
// Behavioural flash: stores words, runs a shortened embedded operation.
// Assumes the host owns every strobe; host timing slips are counted in viol.
module fbc_flash_model #(
  parameter int T_OP_NS = 4000,
  parameter logic [15:0] CMD_GO = 16'h0030
) (
  // Host pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic restart_n,
  input wire logic restart_hv,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_out,
  // Device outputs
  output logic [15:0] dq_in,
  output logic done_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0;
  logic [15:0] rd_val;
  logic [15:0] wd;
  logic [3:0] wa;
  logic [2:0] prot_a;
  logic tog = 1'b0;
  logic wr_ok = 1'b0;
  realtime t_we = -1.0e6;
  realtime t_up = -1.0e6;
  realtime t_rh = -1.0e6;
  realtime t_hv = 0.0;
  int viol = 0;
  initial done_flag = 1'b1;
  initial foreach (mem[i]) mem[i] = 16'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // Pins are looked at a little after the strobe edge, since select may move with it
  always @(negedge we_n) begin
    #5;
    if (!ce_n) begin
      if ($realtime - t_we < 150.0) viol++;
      if ($realtime - t_up < 30.0) viol++;
      if (restart_hv) prot_a = {addr[6], addr[1], addr[0]};
      if (restart_hv && $realtime - t_hv < 4000.0) viol++;
      t_we = $realtime;
      #15 wa = addr[3:0];
      wd = dq_out;
      wr_ok = 1'b1;
    end
  end
  // Pre-programming is folded into the one shortened operation time
  // Byte, word, boosted and erase runs share that shortened time
  always @(posedge we_n) begin : op
    t_up = $realtime;
    if (wr_ok && wd != CMD_GO) mem[wa] = wd;
    if (wr_ok && wd == CMD_GO) begin
      wr_ok = 1'b0;
      #100 done_flag = 1'b0;
      #(T_OP_NS) done_flag = 1'b1;
    end
    wr_ok = 1'b0;
  end
  // Idle restart leaves the device ready at once
  always @(negedge restart_n) if (!done_flag) begin
    #1000 disable op;
    done_flag = 1'b1;
  end
  always @(posedge restart_n) t_rh = $realtime;
  always @(posedge restart_hv) t_hv = $realtime;
  ////////////////////////////////////////////////////////////////////////////////
  // No sector is erase-suspended, so the suspend bit stays still
  assign rd_val = done_flag ? mem[addr[3:0]] : {9'h0, tog, 6'h0};
  // Word mode only: the upper byte never floats
  assign dq_in = (!ce_n && !oe_n) ? rd_val : ~last;
  always @(posedge oe_n) last = rd_val;
  always @(negedge oe_n or negedge ce_n) begin
    #1;
    if (!ce_n && !oe_n) begin
      if ($realtime - t_rh < 201.0) viol++;
      if (!done_flag) tog = ~tog;
    end
  end
endmodule

// file: tb/tb_flash_bus_timing_control.sv
// Self-checking bench for the flash host, facing the behavioural flash.
// Assumes design files and the checker are compiled first.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_flash_bus_timing_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] GO = 16'h0030;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_last = 1'b0;
  logic req_fast = 1'b0;
  fbc_pkg::fbc_op_type req_op = fbc_pkg::FBC_OP_READ;
  logic [19:0] req_addr = 20'h0;
  logic [15:0] req_wdata = 16'h0;
  logic req_ready, rsp_valid, dev_busy, ce_n, oe_n, we_n, rs_n, hv, dq_oe, done;
  logic [15:0] rsp_rdata, dq_out, dq_in;
  logic [19:0] fa;
  int mismatches = 0;
  int n_tests = 0;
  fbc_host uut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_last(req_last), .req_fast_status(req_fast), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .dev_busy(dev_busy), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_restart_n(rs_n), .flash_restart_hv(hv), .flash_addr(fa),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .done_flag_in(done));
  fbc_flash_model #(.T_OP_NS(4000), .CMD_GO(GO)) dev (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .restart_n(rs_n), .restart_hv(hv), .addr(fa), .dq_out(dq_out),
    .dq_in(dq_in), .done_flag(done));
  initial forever #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic till(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic issue(input fbc_pkg::fbc_op_type op, input logic [19:0] a,
    input logic [15:0] d, input logic lst);
    int n;
    @(negedge sys_clk);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_last = lst;
    req_valid = 1'b1;
    till(req_ready, 1'b1, 2000, n);
    `CHK(req_ready, 1'b1)
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [15:0] d);
    int n;
    issue(fbc_pkg::FBC_OP_READ, a, 16'h0, 1'b0);
    till(rsp_valid, 1'b1, 60, n);
    `CHK(rsp_valid, 1'b1)
    d = rsp_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    logic [15:0] d;
    issue(fbc_pkg::FBC_OP_WRITE, 20'h3, 16'h1234, 1'b0);
    issue(fbc_pkg::FBC_OP_WRITE, 20'h4, 16'h5678, 1'b0);
    req_fast = 1'b1;
    rd(20'h3, d);
    `CHK(d, 16'h1234)
    req_fast = 1'b0;
    @(negedge sys_clk);
    `CHK({ce_n, oe_n}, 2'b01)
    rd(20'h4, d);
    `CHK(d, 16'h5678)
    @(negedge sys_clk);
    `CHK(ce_n, 1'b1)
  endtask
  task automatic t_program();
    logic [15:0] d;
    int n;
    issue(fbc_pkg::FBC_OP_WRITE, 20'h5, GO, 1'b1);
    till(dev_busy, 1'b1, 20, n);
    `CHK(dev_busy, 1'b1)
    till(req_ready, 1'b1, 400, n);
    `CHK(n > 90 && n < 120, 1'b1)
    rd(20'h3, d);
    `CHK(d, 16'h1234)
  endtask
  task automatic t_restart();
    logic [15:0] d;
    int n;
    issue(fbc_pkg::FBC_OP_RESTART, 20'h0, 16'h0, 1'b0);
    till(req_ready, 1'b1, 200, n);
    `CHK(n < 60, 1'b1)
    rd(20'h4, d);
    `CHK(d, 16'h5678)
    issue(fbc_pkg::FBC_OP_WRITE, 20'h6, GO, 1'b1);
    till(dev_busy, 1'b1, 20, n);
    issue(fbc_pkg::FBC_OP_RESTART, 20'h0, 16'h0, 1'b0);
    till(req_ready, 1'b1, 700, n);
    `CHK(n < 60, 1'b1)
    `CHK(dev_busy, 1'b0)
    rd(20'h3, d);
    `CHK(d, 16'h1234)
  endtask
  task automatic t_prot();
    int n;
    issue(fbc_pkg::FBC_OP_PROTECT, 20'h20005, 16'h0, 1'b0);
    till(req_ready, 1'b1, 400, n);
    `CHK(dev.prot_a, 3'h2)
    issue(fbc_pkg::FBC_OP_UNPROTECT, 20'h20005, 16'h0, 1'b0);
    till(req_ready, 1'b1, 400, n);
    `CHK(dev.prot_a, 3'h6)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    t_plain();
    t_program();
    t_restart();
    t_prot();
    `CHK(dev.viol, 0)
    conclude();
  end
endmodule
